/* tb/cks_osc_model.sv */
// Behavioural oscillator sources with ready flags for the clock switch
`timescale 1ns/1ns
`default_nettype none
module cks_osc_model (
   input wire logic mclk,
   input wire logic ext_run,
   output logic [4:0] osc_pin,
   output logic [4:0] osc_ready_pin
);
   logic [3:0] cnt_q = 4'h0;
   always @(posedge mclk) begin
      cnt_q <= cnt_q + 4'h1;
   end
   // Stopped external crystal and its PLL leave their lines low
   assign osc_pin = {cnt_q[0] & ext_run, cnt_q[2], cnt_q[3], cnt_q[1], cnt_q[1] & ext_run};
   assign osc_ready_pin = {ext_run, 3'h7, ext_run};
endmodule // cks_osc_model
`default_nettype wire

/* tb/cks_sva.sv */
// Assertion checker on the clock switch register bus and interrupt pin
`timescale 1ns/1ns
`default_nettype none
`include "cks_map.vh"
module cks_sva (
   input wire mclk,
   input wire reset,
   input wire [13:0] address,
   input wire read,
   input wire write,
   input wire [31:0] readdata,
   input wire waitrequest,
   input wire irq
);
   wire rd_done = read && !waitrequest;
   wire wr_done = write && !waitrequest;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   property p_wait_first;
      $rose(read || write) |-> waitrequest;
   endproperty
   a_wait_first: assert property (p_wait_first) else $error("request not stalled first cycle");
   property p_wait_one;
      waitrequest |=> !waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("more than one wait cycle");
   property p_req_fields;
      rd_done && address[13:2] == `CKS_IDX_REQUEST |->
         !readdata[7] && readdata[6:4] != 3'h0 && readdata[6:4] != 3'h1 && readdata[6:4] != 3'h3;
   endproperty
   a_req_fields: assert property (p_req_fields) else $error("request holds reserved source");
   property p_cur_fields;
      rd_done && address[13:2] == `CKS_IDX_CURRENT |->
         !readdata[7] && readdata[6:4] != 3'h0 && readdata[6:4] != 3'h1 && readdata[6:4] != 3'h3;
   endproperty
   a_cur_fields: assert property (p_cur_fields) else $error("current holds reserved source");
   property p_ctl_excl;
      rd_done && address[13:2] == `CKS_IDX_CONTROL |-> !(readdata[4] && readdata[3]);
   endproperty
   a_ctl_excl: assert property (p_ctl_excl) else $error("complete and new ready both set");
   property p_upper_zero;
      rd_done |-> readdata[31:8] == 24'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
   property p_rd_hold;
      !$past(read) && !$past(reset) |-> $stable(readdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data changed without read");
   property p_irq_reset;
      disable iff (1'b0) reset |=> !irq;
   endproperty
   a_irq_reset: assert property (p_irq_reset) else $error("interrupt high after reset");
   property p_irq_hold;
      irq && !wr_done |=> irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without write");
   c_irq: cover property ($rose(irq));
   c_cur_read: cover property (rd_done && address[13:2] == `CKS_IDX_CURRENT);
   c_write: cover property (wr_done);
endmodule // cks_sva
bind cks_switch cks_sva u_sva (.mclk(mclk), .reset(reset), .address(address), .read(read),
   .write(write), .readdata(readdata), .waitrequest(waitrequest), .irq(irq));
`default_nettype wire

/* tb/testbench.sv */
// Self-checking testbench for the clock source switch
`timescale 1ns/1ns
`default_nettype none
`include "cks_map.vh"
module testbench;
   logic mclk, reset, read, write, sleep_req, wake_req, ext_run;
   logic cfg_switch_enable, cfg_ext_clock_mode, cfg_fail_safe_en;
   logic [13:0] address;
   logic [31:0] writedata;
   logic [2:0] cfg_reset_osc;
   wire [31:0] readdata;
   wire waitrequest, sys_clk, irq;
   wire [4:0] osc_pin, osc_ready_pin;
   wire [3:0] internal_freq_select;
   wire [5:0] internal_osc_tune;
   wire [7:0] osc_manual_enable;
   wire secondary_osc_power;
   int mismatches, checks_done, seed, n;
   logic [7:0] v, e;
   logic [2:0] srcs [5] = '{3'h5, 3'h4, 3'h7, 3'h2, 3'h6};
   logic [2:0] rsv [3] = '{3'h0, 3'h1, 3'h3};
   cks_switch #(.OST_EDGES(8)) dut (.mclk(mclk), .reset(reset), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .osc_pin(osc_pin), .osc_ready_pin(osc_ready_pin), .cfg_reset_osc(cfg_reset_osc),
      .cfg_switch_enable(cfg_switch_enable), .cfg_ext_clock_mode(cfg_ext_clock_mode),
      .cfg_fail_safe_en(cfg_fail_safe_en), .sleep_req(sleep_req), .wake_req(wake_req),
      .sys_clk(sys_clk), .irq(irq), .internal_freq_select(internal_freq_select),
      .internal_osc_tune(internal_osc_tune), .osc_manual_enable(osc_manual_enable),
      .secondary_osc_power(secondary_osc_power));
   cks_osc_model osc (.mclk(mclk), .ext_run(ext_run), .osc_pin(osc_pin),
      .osc_ready_pin(osc_ready_pin));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // ***************************************
   // Bus, check and expectation helpers
   // ***************************************
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] wd,
                      output logic [7:0] rdv);
      int k;
      k = 0;
      address <= {idx, 2'b00};
      writedata <= {24'h0, wd};
      read <= !w;
      write <= w;
      do begin
         @(posedge mclk);
         k++;
      end while (waitrequest !== 1'b0 && k < 50);
      rdv = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
      if (k >= 50) begin
         mismatches++;
         report_and_stop;
      end
      @(posedge mclk);
   endtask
   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      logic [7:0] x;
      bus(1'b1, idx, d, x);
   endtask
   task automatic rd(input logic [11:0] idx, output logic [7:0] x);
      bus(1'b0, idx, 8'h00, x);
   endtask
   task automatic do_reset(input logic [2:0] cfg);
      cfg_reset_osc <= cfg;
      reset <= 1'b1;
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wait_cur(input logic [7:0] x);
      int k;
      k = 0;
      do begin
         rd(`CKS_IDX_CURRENT, v);
         k++;
      end while (v !== x && k < 1000);
      chk("current", v, x);
      if (v !== x) report_and_stop;
   endtask
   task automatic chk_irq(input logic x);
      @(negedge mclk);
      chk("irq", irq, x);
      @(posedge mclk);
   endtask
   task automatic chk_period(input int x);
      int k, r, t;
      logic p;
      k = 0;
      r = 0;
      t = 0;
      p = sys_clk;
      while (r < 2 && k < 2000) begin
         @(negedge mclk);
         k++;
         if (sys_clk === 1'b1 && p === 1'b0) begin
            r++;
            if (r == 1) t = k;
         end
         p = sys_clk;
      end
      chk("sys_clk period", k - t, x);
      if (k >= 2000) report_and_stop;
   endtask
   task automatic pulse(input logic slp);
      sleep_req <= slp;
      wake_req <= !slp;
      @(posedge mclk);
      sleep_req <= 1'b0;
      wake_req <= 1'b0;
      @(posedge mclk);
   endtask
   function automatic logic [7:0] rst_val(input logic [2:0] c);
      if (c == `CKS_RST_HF64) return 8'h60;
      if (c == `CKS_RST_HF4) return 8'h62;
      return {1'b0, c, 4'h0};
   endfunction
   // ***************************************
   // Main sequence
   // ***************************************
   initial begin
      seed = 17;
      mismatches = 0;
      checks_done = 0;
      reset = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 14'h0;
      writedata = 32'h0;
      sleep_req = 1'b0;
      wake_req = 1'b0;
      ext_run = 1'b1;
      cfg_reset_osc = 3'h6;
      cfg_switch_enable = 1'b1;
      cfg_ext_clock_mode = 1'b0;
      cfg_fail_safe_en = 1'b0;
      @(posedge mclk);
      for (int c = 0; c < 8; c++) begin
         if (c != 1 && c != 3) begin
            do_reset(c[2:0]);
            rd(`CKS_IDX_REQUEST, v);
            chk("request reset", v, rst_val(c[2:0]));
            rd(`CKS_IDX_CURRENT, v);
            chk("current reset", v, rst_val(c[2:0]));
            chk("freq select", internal_freq_select, c == 0 ? 4'h8 : 4'h2);
         end
      end
      do_reset(3'h6);
      rd(12'h100, v);
      chk("unmapped", v, 8'h00);
      rd(`CKS_IDX_READY, v);
      chk("ready status", v, 8'hF9);
      wr(`CKS_IDX_FREQ, 8'h35);
      rd(`CKS_IDX_FREQ, v);
      chk("freq write", {v, 4'h0, internal_freq_select}, 16'h0505);
      wr(`CKS_IDX_TUNE, 8'hEA);
      rd(`CKS_IDX_TUNE, v);
      chk("tune", {v, 2'h0, internal_osc_tune}, 16'h2A2A);
      wr(`CKS_IDX_MANUAL, 8'hFF);
      rd(`CKS_IDX_MANUAL, v);
      chk("manual enable", {v, osc_manual_enable}, 16'hFCFC);
      wr(`CKS_IDX_CONTROL, 8'h40);
      rd(`CKS_IDX_CONTROL, v);
      chk("secondary power", {v, 7'h0, secondary_osc_power}, 16'h5001);
      wr(`CKS_IDX_CURRENT, 8'h55);
      rd(`CKS_IDX_CURRENT, v);
      chk("current read only", v, 8'h62);
      foreach (rsv[i]) begin
         e = {4'h6, i == 0 ? 4'h9 : 4'($unsigned($random(seed)) % 10)};
         wr(`CKS_IDX_REQUEST, {1'b0, rsv[i], e[3:0]});
         rd(`CKS_IDX_REQUEST, v);
         chk("reserved source", v, e);
      end
      wr(`CKS_IDX_REQUEST, 8'h60);
      wait_cur(8'h60);
      chk_period(4);
      wr(`CKS_IDX_IRQ_MASK, 8'h01);
      wr(`CKS_IDX_IRQ_STAT, 8'h03);
      foreach (srcs[i]) begin
         e = {1'b0, srcs[i], 4'($unsigned($random(seed)) % 2)};
         wr(`CKS_IDX_REQUEST, e);
         wait_cur(e);
         rd(`CKS_IDX_CONTROL, v);
         chk("complete", v & 8'h18, 8'h10);
         rd(`CKS_IDX_IRQ_STAT, v);
         chk("switch flag", v & 8'h01, 8'h01);
         chk_irq(1'b1);
         wr(`CKS_IDX_IRQ_STAT, 8'h01);
         chk_irq(1'b0);
      end
      wr(`CKS_IDX_IRQ_MASK, 8'h00);
      wr(`CKS_IDX_REQUEST, 8'h61);
      wait_cur(8'h61);
      chk_period(8);
      rd(`CKS_IDX_IRQ_STAT, v);
      chk("masked flag", v & 8'h01, 8'h01);
      chk_irq(1'b0);
      wr(`CKS_IDX_IRQ_STAT, 8'h01);
      wr(`CKS_IDX_CONTROL, 8'h80);
      wr(`CKS_IDX_REQUEST, 8'h60);
      n = 0;
      do begin
         rd(`CKS_IDX_CONTROL, v);
         n++;
      end while (v[3] !== 1'b1 && n < 100);
      if (n >= 100) report_and_stop;
      chk("held new ready", v, 8'h88);
      rd(`CKS_IDX_CURRENT, v);
      chk("held current", v, 8'h61);
      rd(`CKS_IDX_IRQ_STAT, v);
      chk("held flag", v & 8'h01, 8'h01);
      pulse(1'b1);
      rd(`CKS_IDX_CONTROL, v);
      chk("sleep abandons", v, 8'h80);
      rd(`CKS_IDX_CURRENT, v);
      chk("sleep current", v, 8'h61);
      pulse(1'b0);
      wr(`CKS_IDX_CONTROL, 8'h00);
      wait_cur(8'h60);
      cfg_switch_enable <= 1'b0;
      do_reset(3'h6);
      wr(`CKS_IDX_REQUEST, 8'h50);
      rd(`CKS_IDX_REQUEST, v);
      chk("locked request", v, 8'h62);
      cfg_switch_enable <= 1'b1;
      ext_run <= 1'b0;
      cfg_fail_safe_en <= 1'b1;
      do_reset(3'h7);
      repeat (1500) @(posedge mclk);
      rd(`CKS_IDX_CURRENT, v);
      chk("no early fail", v, 8'h70);
      rd(`CKS_IDX_IRQ_STAT, v);
      chk("no fail flag", v & 8'h02, 8'h00);
      cfg_ext_clock_mode <= 1'b1;
      do_reset(3'h7);
      wait_cur(8'h60);
      rd(`CKS_IDX_IRQ_STAT, v);
      chk("fail flag", v & 8'h02, 8'h02);
      report_and_stop;
   end
endmodule // testbench
`default_nettype wire

/* verilog/cks_map.vh */
// Register map, field layout and codes of the clock source switch
`ifndef CKS_MAP_VH
`define CKS_MAP_VH
// Register indices, byte address is four times the index
`define CKS_IDX_REQUEST 12'hED8
`define CKS_IDX_CURRENT 12'hED9
`define CKS_IDX_CONTROL 12'hEDA
`define CKS_IDX_READY 12'hEDB
`define CKS_IDX_MANUAL 12'hEDC
`define CKS_IDX_TUNE 12'hEDD
`define CKS_IDX_FREQ 12'hEDE
`define CKS_IDX_IRQ_STAT 12'hEDF
`define CKS_IDX_IRQ_MASK 12'hEE0
// Field positions
`define CKS_SRC_RANGE 6:4
`define CKS_DIV_RANGE 3:0
`define CKS_CTL_HOLD 7
`define CKS_CTL_SECPWR 6
`define CKS_CTL_COMPLETE 4
`define CKS_CTL_NEWRDY 3
`define CKS_IRQ_SWITCH 0
`define CKS_IRQ_FAIL 1
// Source codes
`define CKS_SRC_EXT 3'h7
`define CKS_SRC_HF 3'h6
`define CKS_SRC_LF 3'h5
`define CKS_SRC_SEC 3'h4
`define CKS_SRC_PLL 3'h2
// Oscillator pin order
`define CKS_OSC_EXT 0
`define CKS_OSC_HF 1
`define CKS_OSC_LF 2
`define CKS_OSC_SEC 3
`define CKS_OSC_PLL 4
// Reset configuration codes and reset values
`define CKS_RST_HF4 3'h6
`define CKS_RST_HF64 3'h0
`define CKS_DIV_ONE 4'h0
`define CKS_DIV_FOUR 4'h2
`define CKS_DIV_MAX 4'h9
`define CKS_FRQ_4MHZ 4'h2
`define CKS_FRQ_64MHZ 4'h8
// Timing
`define CKS_OST_EDGES 1024
`define CKS_SAMPLE_HALF 5'h1F
`endif

/* verilog/cks_postscaler.v */
// Postscaler that builds the system clock from the selected source level
`timescale 1ns/1ns
`default_nettype none
`include "cks_map.vh"
module cks_postscaler #(
   parameter CNT_W = 9
) (
   input wire mclk,
   input wire reset,
   input wire [4:0] osc_lvl,
   input wire [2:0] src_sel,
   input wire [3:0] div_sel,
   input wire restart,
   input wire run,
   output reg sys_clk_q,
   output reg low_start_q
);
   reg lvl;
   reg prev_q;
   reg [CNT_W-1:0] cnt_q;
   wire [3:0] div_eff;
   wire [CNT_W-1:0] half_last;
   wire edge_seen;

   // ****************************************
   // Source mux
   // ****************************************
   always @* begin
      case (src_sel)
         `CKS_SRC_EXT: lvl = osc_lvl[`CKS_OSC_EXT];
         `CKS_SRC_LF: lvl = osc_lvl[`CKS_OSC_LF];
         `CKS_SRC_SEC: lvl = osc_lvl[`CKS_OSC_SEC];
         `CKS_SRC_PLL: lvl = osc_lvl[`CKS_OSC_PLL];
         default: lvl = osc_lvl[`CKS_OSC_HF];
      endcase
   end

   // Reserved divider codes act as the largest ratio
   // (R5) power of two ratio
   assign div_eff = (div_sel > `CKS_DIV_MAX) ? `CKS_DIV_MAX : div_sel;
   assign half_last = (({{(CNT_W-1){1'b0}}, 1'b1} << div_eff) - 1'b1);
   assign edge_seen = lvl ^ prev_q;

   // ****************************************
   // Whole-phase divider
   // ****************************************
   // (R18) whole phases only
   always @(posedge mclk) begin
      if (reset) begin
         prev_q <= 1'b0;
         cnt_q <= {CNT_W{1'b0}};
         sys_clk_q <= 1'b0;
         low_start_q <= 1'b0;
      end else if (restart) begin
         prev_q <= lvl;
         cnt_q <= {CNT_W{1'b0}};
         low_start_q <= 1'b0;
      end else begin
         prev_q <= lvl;
         low_start_q <= 1'b0;
         if (run && edge_seen) begin
            if (cnt_q == half_last) begin
               cnt_q <= {CNT_W{1'b0}};
               sys_clk_q <= ~sys_clk_q;
               low_start_q <= sys_clk_q;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end
endmodule // cks_postscaler
`default_nettype wire

/* verilog/cks_switch.v */
// Clock source and postscaler switch control with fail-safe monitor
`timescale 1ns/1ns
`default_nettype none
`include "cks_map.vh"
// Contract
// (R1) Fail-safe monitor checks the external oscillator only after start-up timer expiry.
// (R2) Start-up timer runs after every reset and every wake from sleep.
// (R3) External clock input mode skips the start-up timer entirely.
// (R4) Requested source bits 6:4; 111,110,101,100,010 valid, others reserved.
// (R5) Requested divider bits 3:0; codes 0..9 divide by two to the code.
// (R6) A reserved source code write leaves the source field unchanged.
// (R7) With switching disabled the request register ignores software writes.
// (R8) Request reset values follow the reset oscillator configuration code.
// (R9) Current source and divider are read-only with request encodings.
// (R10) At reset current fields equal the request fields.
// (R11) Internal oscillator frequency comes from the frequency select field.
// (R12) Hold set: suspend the switch when ready, raise the switch flag.
// (R13) Hold clear: switch as soon as new oscillator ready sets.
// (R14) New-ready status and switch flag set together when source ready.
// (R15) On switch load current fields, set complete, clear new-ready.
// (R16) On external failure force current source to internal, set fail flag.
// (R17) Sleep before switch completes abandons the switch.
// (R18) Source or divider change never truncates system clock phases.
module cks_switch #(
   parameter OST_EDGES = `CKS_OST_EDGES,
   parameter OST_W = 11
) (
   input wire mclk,
   input wire reset,
   input wire [13:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output wire waitrequest,
   input wire [4:0] osc_pin,
   input wire [4:0] osc_ready_pin,
   input wire [2:0] cfg_reset_osc,
   input wire cfg_switch_enable,
   input wire cfg_ext_clock_mode,
   input wire cfg_fail_safe_en,
   input wire sleep_req,
   input wire wake_req,
   output wire sys_clk,
   output wire irq,
   output wire [3:0] internal_freq_select,
   output wire [5:0] internal_osc_tune,
   output wire [7:0] osc_manual_enable,
   output wire secondary_osc_power
);
   reg [4:0] lvl_s1_q;
   reg [4:0] lvl_q;
   reg [4:0] rdy_s1_q;
   reg [4:0] rdy_q;
   reg ack_q;
   reg [2:0] req_src_q;
   reg [3:0] req_div_q;
   reg [2:0] cur_src_q;
   reg [3:0] cur_div_q;
   reg hold_q;
   reg secpwr_q;
   reg new_rdy_q;
   reg [7:0] manual_q;
   reg [5:0] tune_q;
   reg [3:0] freq_q;
   reg [1:0] irq_stat_q;
   reg [1:0] irq_mask_q;
   reg sleeping_q;
   reg restart_q;
   reg [OST_W-1:0] ost_cnt_q;
   reg ost_done_q;
   reg fail_q;
   reg ext_prev_q;
   reg lf_prev_q;
   reg [4:0] smp_cnt_q;
   reg smp_q;
   reg seen_fall_q;
   reg sel_rdy;
   reg [1:0] irq_stat_d;
   reg [7:0] rd_byte;
   wire [11:0] idx;
   wire wr_go;
   wire rd_go;
   wire pending;
   wire ext_based;
   wire low_start;
   wire do_switch;
   wire ready_event;
   wire ext_fall;
   wire lf_rise;
   wire smp_tick;
   wire fail_event;
   wire src_reserved;
   wire [2:0] wr_src;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   always @(posedge mclk) begin
      if (reset) begin
         lvl_s1_q <= 5'h00;
         lvl_q <= 5'h00;
         rdy_s1_q <= 5'h00;
         rdy_q <= 5'h00;
      end else begin
         lvl_s1_q <= osc_pin;
         lvl_q <= lvl_s1_q;
         rdy_s1_q <= osc_ready_pin;
         rdy_q <= rdy_s1_q;
      end
   end

   // ****************************************
   // Avalon-MM slave, one wait cycle
   // ****************************************
   assign idx = address[13:2];
   assign waitrequest = (read | write) & ~ack_q;
   assign wr_go = write & ack_q;
   assign rd_go = read & ~ack_q;
   assign wr_src = writedata[`CKS_SRC_RANGE];

   // (R4) reserved source codes
   assign src_reserved = (wr_src != `CKS_SRC_EXT) && (wr_src != `CKS_SRC_HF) &&
      (wr_src != `CKS_SRC_LF) && (wr_src != `CKS_SRC_SEC) && (wr_src != `CKS_SRC_PLL);

   always @* begin
      case (idx)
         `CKS_IDX_REQUEST: rd_byte = {1'b0, req_src_q, req_div_q};
         // (R9) current fields read-only
         `CKS_IDX_CURRENT: rd_byte = {1'b0, cur_src_q, cur_div_q};
         `CKS_IDX_CONTROL: rd_byte = {hold_q, secpwr_q, 1'b0, ~pending, new_rdy_q, 3'h0};
         `CKS_IDX_READY: rd_byte = {rdy_q[`CKS_OSC_EXT], rdy_q[`CKS_OSC_HF],
            rdy_q[`CKS_OSC_HF], rdy_q[`CKS_OSC_LF], rdy_q[`CKS_OSC_SEC], 2'h0,
            rdy_q[`CKS_OSC_PLL]};
         `CKS_IDX_MANUAL: rd_byte = {manual_q[7:2], 2'h0};
         `CKS_IDX_TUNE: rd_byte = {2'h0, tune_q};
         `CKS_IDX_FREQ: rd_byte = {4'h0, freq_q};
         `CKS_IDX_IRQ_STAT: rd_byte = {6'h00, irq_stat_q};
         `CKS_IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask_q};
         default: rd_byte = 8'h00;
      endcase
   end

   always @(posedge mclk) begin
      if (reset) begin
         ack_q <= 1'b0;
         readdata <= 32'h00000000;
      end else begin
         ack_q <= (read | write) & ~ack_q;
         if (rd_go) begin
            readdata <= {24'h000000, rd_byte};
         end
      end
   end

   // ****************************************
   // Source readiness and switch decision
   // ****************************************
   assign ext_based = (cur_src_q == `CKS_SRC_EXT) || (cur_src_q == `CKS_SRC_PLL);

   // External sources count as ready only after the start-up timer
   always @* begin
      case (req_src_q)
         `CKS_SRC_EXT: sel_rdy = rdy_q[`CKS_OSC_EXT] & ost_done_q;
         `CKS_SRC_LF: sel_rdy = rdy_q[`CKS_OSC_LF];
         `CKS_SRC_SEC: sel_rdy = rdy_q[`CKS_OSC_SEC];
         `CKS_SRC_PLL: sel_rdy = rdy_q[`CKS_OSC_PLL] & ost_done_q;
         default: sel_rdy = rdy_q[`CKS_OSC_HF];
      endcase
   end

   // After a failure the old request is not retried until rewritten or sleep is requested
   assign pending = ((req_src_q != cur_src_q) || (req_div_q != cur_div_q)) & ~fail_q;
   // (R14) ready event
   assign ready_event = pending & sel_rdy & ~new_rdy_q & ~sleeping_q;
   // (R13) switch at next low phase
   assign do_switch = new_rdy_q & ~hold_q & low_start & ~sleeping_q;

   // ****************************************
   // Control registers
   // ****************************************
   always @(posedge mclk) begin
      if (reset) begin
         // (R8) reset values
         req_src_q <= (cfg_reset_osc == `CKS_RST_HF64) ? `CKS_SRC_HF : cfg_reset_osc;
         req_div_q <= (cfg_reset_osc == `CKS_RST_HF4) ? `CKS_DIV_FOUR : `CKS_DIV_ONE;
         // (R10) current equals request
         cur_src_q <= (cfg_reset_osc == `CKS_RST_HF64) ? `CKS_SRC_HF : cfg_reset_osc;
         cur_div_q <= (cfg_reset_osc == `CKS_RST_HF4) ? `CKS_DIV_FOUR : `CKS_DIV_ONE;
         freq_q <= (cfg_reset_osc == `CKS_RST_HF64) ? `CKS_FRQ_64MHZ : `CKS_FRQ_4MHZ;
         hold_q <= 1'b0;
         secpwr_q <= 1'b0;
         new_rdy_q <= 1'b0;
         manual_q <= 8'h00;
         tune_q <= 6'h00;
         irq_mask_q <= 2'h0;
         restart_q <= 1'b0;
      end else begin
         restart_q <= 1'b0;
         if (wr_go) begin
            // (R7) locked when disabled
            if ((idx == `CKS_IDX_REQUEST) && cfg_switch_enable) begin
               // (R6) reserved source ignored
               if (!src_reserved) begin
                  req_src_q <= wr_src;
               end
               req_div_q <= writedata[`CKS_DIV_RANGE];
            end
            if (idx == `CKS_IDX_CONTROL) begin
               hold_q <= writedata[`CKS_CTL_HOLD];
               secpwr_q <= writedata[`CKS_CTL_SECPWR];
            end
            if (idx == `CKS_IDX_MANUAL) begin
               manual_q <= {writedata[7:2], 2'h0};
            end
            if (idx == `CKS_IDX_TUNE) begin
               tune_q <= writedata[5:0];
            end
            if (idx == `CKS_IDX_FREQ) begin
               freq_q <= writedata[3:0];
            end
            if (idx == `CKS_IDX_IRQ_MASK) begin
               irq_mask_q <= writedata[1:0];
            end
         end
         if (fail_event) begin
            // (R16) fall back to internal
            cur_src_q <= `CKS_SRC_HF;
            new_rdy_q <= 1'b0;
            restart_q <= 1'b1;
         end else if (do_switch) begin
            // (R15) load current fields
            cur_src_q <= req_src_q;
            cur_div_q <= req_div_q;
            new_rdy_q <= 1'b0;
            restart_q <= 1'b1;
         end else if (sleep_req || (wr_go && (idx == `CKS_IDX_REQUEST))) begin
            // (R17) abandon on sleep
            new_rdy_q <= 1'b0;
         end else if (ready_event) begin
            // (R12) suspend while hold set
            new_rdy_q <= 1'b1;
         end
      end
   end

   // ****************************************
   // Sleep and oscillator start-up timer
   // ****************************************
   always @(posedge mclk) begin
      if (reset) begin
         sleeping_q <= 1'b0;
         ost_cnt_q <= {OST_W{1'b0}};
         ost_done_q <= 1'b0;
      end else begin
         if (sleep_req) begin
            sleeping_q <= 1'b1;
         end else if (wake_req) begin
            sleeping_q <= 1'b0;
         end
         // (R2) restart after wake
         if (sleep_req || wake_req) begin
            ost_cnt_q <= {OST_W{1'b0}};
            ost_done_q <= 1'b0;
         // (R3) skipped in clock input mode
         end else if (cfg_ext_clock_mode) begin
            ost_done_q <= 1'b1;
         end else if (!ost_done_q && !sleeping_q && ext_fall) begin
            if (ost_cnt_q == OST_EDGES[OST_W-1:0] - 1'b1) begin
               ost_done_q <= 1'b1;
            end
            ost_cnt_q <= ost_cnt_q + 1'b1;
         end
      end
   end

   // ****************************************
   // Fail-safe monitor
   // ****************************************
   assign ext_fall = ext_prev_q & ~lvl_q[`CKS_OSC_EXT];
   assign lf_rise = ~lf_prev_q & lvl_q[`CKS_OSC_LF];
   assign smp_tick = lf_rise && (smp_cnt_q == `CKS_SAMPLE_HALF);
   // (R1) armed after start-up timer
   assign fail_event = smp_tick & smp_q & ~seen_fall_q & ost_done_q & cfg_fail_safe_en &
      ext_based & ~fail_q & ~sleeping_q;

   always @(posedge mclk) begin
      if (reset) begin
         ext_prev_q <= 1'b0;
         lf_prev_q <= 1'b0;
         smp_cnt_q <= 5'h00;
         smp_q <= 1'b0;
         seen_fall_q <= 1'b0;
         fail_q <= 1'b0;
      end else begin
         ext_prev_q <= lvl_q[`CKS_OSC_EXT];
         lf_prev_q <= lvl_q[`CKS_OSC_LF];
         if (lf_rise) begin
            smp_cnt_q <= smp_cnt_q + 1'b1;
         end
         if (smp_tick) begin
            smp_q <= ~smp_q;
         end
         // Latch set by external falls, cleared on sample rise
         if (ext_fall) begin
            seen_fall_q <= 1'b1;
         end else if (smp_tick && !smp_q) begin
            seen_fall_q <= 1'b0;
         end
         if (fail_event) begin
            fail_q <= 1'b1;
         end else if (sleep_req || (wr_go && (idx == `CKS_IDX_REQUEST))) begin
            fail_q <= 1'b0;
         end
      end
   end

   // ****************************************
   // Interrupt flags
   // ****************************************
   always @* begin
      irq_stat_d = irq_stat_q;
      if (wr_go && (idx == `CKS_IDX_IRQ_STAT)) begin
         irq_stat_d = irq_stat_q & ~writedata[1:0];
      end
      // (R14) switch flag with ready
      if (ready_event) begin
         irq_stat_d[`CKS_IRQ_SWITCH] = 1'b1;
      end
      // (R16) fail flag
      if (fail_event) begin
         irq_stat_d[`CKS_IRQ_FAIL] = 1'b1;
      end
   end

   always @(posedge mclk) begin
      if (reset) begin
         irq_stat_q <= 2'h0;
      end else begin
         irq_stat_q <= irq_stat_d;
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   // ****************************************
   // System clock generation
   // ****************************************
   // (R18) switch at phase boundary
   cks_postscaler u_post (
      .mclk(mclk),
      .reset(reset),
      .osc_lvl(lvl_q),
      .src_sel(cur_src_q),
      .div_sel(cur_div_q),
      .restart(restart_q),
      .run(~sleeping_q),
      .sys_clk_q(sys_clk),
      .low_start_q(low_start)
   );

   // (R11) internal frequency select
   assign internal_freq_select = freq_q;
   assign internal_osc_tune = tune_q;
   assign osc_manual_enable = manual_q;
   assign secondary_osc_power = secpwr_q;
endmodule // cks_switch
`default_nettype wire
